// *** verilog/rtc_consts.svh ***
// Register offsets, field positions, reset values and counts of the periodic counter
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH

// =============================================
// Register offsets
`define TSC_OFFSET   2'h0
`define COUNT_OFFSET 2'h1
`define LIMIT_OFFSET 2'h2

// =============================================
// Status and control field positions
`define FLAG_BIT  7
`define SEL_HI    6
`define SEL_LO    5
`define IE_BIT    4
`define PS_HI     3
`define PS_LO     0

// =============================================
// Reset values and constants
`define BYTE_ZERO  8'h00
`define BYTE_ONE   8'h01
`define SEL_RESET  2'h0
`define PS_OFF     4'h0
`define DIV_ONE    18'h0_0001
`define DIV_ZERO   18'h0_0000

`endif

// *** verilog/rtc_pkg.sv ***
// Types shared by the periodic counter modules
package rtc_pkg;
	// Clock source chosen by the source select field
	typedef enum logic [1:0] {
		src_low_power,
		src_ext,
		src_int
	} source_t;

	// Prescaler divide ratio
	typedef logic [17:0] prescale_div_t;

	// Byte wide register value
	typedef logic [7:0] byte_t;
endpackage

// *** verilog/source_edge_sync.sv ***
// Two-flop synchronisers with rising edge detect for the counting clock sources
`timescale 1ns/1ps

module source_edge_sync #(
	parameter int N = 3
) (
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic [N-1:0] raw,
	output logic      [N-1:0] rise
);

	// =============================================
	// One synchroniser per source
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_sync
			logic meta_q, meta_d;
			logic sync_q, sync_d;
			logic last_q, last_d;

			// Next values; first flop feeds only the second
			always_comb begin
				meta_d = raw[g];
				sync_d = meta_q;
				last_d = sync_q;
				if (reset) begin
					meta_d = 1'b0;
					sync_d = 1'b0;
					last_d = 1'b0;
				end
			end

			// Register stage
			always_ff @(posedge clk) begin
				meta_q <= meta_d;
				sync_q <= sync_d;
				last_q <= last_d;
			end

			// Rising edge of the synchronised source
			assign rise[g] = sync_q & ~last_q;
		end
	endgenerate

endmodule // source_edge_sync

// *** verilog/rtc_prescaler.sv ***
// Prescaler that divides the selected source edges by a table ratio
`timescale 1ns/1ps
`include "rtc_consts.svh"

module rtc_prescaler #(
	parameter int DIV_W = 18
) (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       clear,
	input  wire logic [3:0] prescale_select,
	input  wire logic       bank,
	input  wire logic       src_edge,
	output logic            tick
);

	logic [DIV_W-1:0]      cnt_q, cnt_d;
	rtc_pkg::prescale_div_t div;
	logic                  run;

	// =============================================
	// Divide ratio table, binary and decimal settings
	function automatic rtc_pkg::prescale_div_t div_of(input logic b, input logic [3:0] ps);
		rtc_pkg::prescale_div_t v;
		v = `DIV_ONE;
		case ({b, ps})
			5'h01: v = 18'h0_0008;
			5'h02: v = 18'h0_0020;
			5'h03: v = 18'h0_0040;
			5'h04: v = 18'h0_0080;
			5'h05: v = 18'h0_0100;
			5'h06: v = 18'h0_0200;
			5'h07: v = 18'h0_0400;
			5'h08: v = 18'h0_0001;
			5'h09: v = 18'h0_0002;
			5'h0a: v = 18'h0_0004;
			5'h0b: v = 18'h0_000a;
			5'h0c: v = 18'h0_0010;
			5'h0d: v = 18'h0_0064;
			5'h0e: v = 18'h0_01f4;
			5'h0f: v = 18'h0_03e8;
			5'h11: v = 18'h0_0400;
			5'h12: v = 18'h0_0800;
			5'h13: v = 18'h0_1000;
			5'h14: v = 18'h0_2000;
			5'h15: v = 18'h0_4000;
			5'h16: v = 18'h0_8000;
			5'h17: v = 18'h1_0000;
			5'h18: v = 18'h0_03e8;
			5'h19: v = 18'h0_07d0;
			5'h1a: v = 18'h0_1388;
			5'h1b: v = 18'h0_2710;
			5'h1c: v = 18'h0_4e20;
			5'h1d: v = 18'h0_c350;
			5'h1e: v = 18'h1_86a0;
			5'h1f: v = 18'h3_0d40;
			default: v = `DIV_ONE;
		endcase
		return v;
	endfunction

	// Ratio and run state; a zero select holds the prescaler off
	assign div  = div_of(bank, prescale_select);
	assign run  = (prescale_select != `PS_OFF);
	assign tick = run & ~clear & src_edge & (cnt_q == DIV_W'(div - `DIV_ONE));

	// Next prescaler count
	always_comb begin
		cnt_d = cnt_q;
		if (reset || clear || !run) begin
			cnt_d = '0;
		end else if (src_edge) begin
			if (tick) begin
				cnt_d = '0;
			end else begin
				cnt_d = cnt_q + DIV_W'(1);
			end
		end
	end

	// Register stage
	always_ff @(posedge clk) begin
		cnt_q <= cnt_d;
	end

	// =============================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	prescale_bound_a: assert property (run && !clear |-> cnt_q < DIV_W'(div))
		else $error("prescaler count above ratio");
	prescale_off_a: assert property (!run |=> cnt_q == '0)
		else $error("prescaler runs while off");

endmodule // rtc_prescaler

// *** verilog/periodic_realtime_counter.sv ***
// Periodic real-time counter with prescaler, compare limit, flag and interrupt
//
// Summary of operation
// - 8-bit up-counter against 8-bit limit, fed by source selector and prescaler.
// - Reset stops counter at zero, clears limit, turns prescaler off.
// - Reset selects the 1 kHz low power oscillator as source.
// - Prescaler off while select is zero; any nonzero value starts it.
// - Source 00 low power, 01 external reference, 1x internal reference.
// - Writing a different source clears prescaler and counter.
// - Writing a different prescale select clears prescaler and counter.
// - Prescale select and source low bit choose the ratio jointly.
// - Ratio table: binary and decimal ratios per source low bit.
// - Limit accepts any byte as match value.
// - Counter steps per prescaler period, wraps to zero after the limit.
// - Flag sets on passing from limit to zero, not before.
// - Limit zero sets the flag on every prescaler period.
// - Any limit write clears prescaler and counter.
// - Interrupt requested while flag set and enable one.
// - Writing one to the flag clears it; a wrap in the same cycle wins.
// - Writing zero leaves flag; clearing withdraws interrupt; reset clears flag.
// - Count readable as a byte; writes to it are ignored.
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "rtc_consts.svh"

module periodic_realtime_counter (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic [1:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	output logic            irq,
	input  wire logic       low_power_osc,
	input  wire logic       external_ref_clock,
	input  wire logic       internal_ref_clock
);

	// =============================================
	// Declarations
	logic [1:0]         source_select_q, source_select_d;
	logic [3:0]         prescale_select_q, prescale_select_d;
	logic               periodic_irq_enable_q, periodic_irq_enable_d;
	logic               periodic_flag_q, periodic_flag_d;
	rtc_pkg::byte_t     compare_limit_q, compare_limit_d;
	rtc_pkg::byte_t     count_value_q, count_value_d;
	rtc_pkg::byte_t     rdata_q, rdata_d;
	logic               irq_q, irq_d;
	logic [2:0]         src_rise;
	logic               src_edge;
	logic               tick;
	logic               clear;
	logic               wrap;
	logic               tsc_wr;
	logic               limit_wr;
	logic [1:0]         new_sel;
	logic [3:0]         new_ps;
	rtc_pkg::source_t   cur_src;

	// =============================================
	// Source decode, used for the source edge mux
	function automatic rtc_pkg::source_t src_of(input logic [1:0] sel);
		rtc_pkg::source_t s;
		s = rtc_pkg::src_low_power;
		if (sel == 2'h0) begin
			s = rtc_pkg::src_low_power;
		end else if (sel == 2'h1) begin
			s = rtc_pkg::src_ext;
		end else begin
			s = rtc_pkg::src_int;
		end
		return s;
	endfunction

	// =============================================
	// Source synchronisers
	source_edge_sync #(
		.N (3)
	) u_sync (
		.clk   (clk),
		.reset (reset),
		.raw   ({internal_ref_clock, external_ref_clock, low_power_osc}),
		.rise  (src_rise)
	);

	// Selected source edge
	assign cur_src = src_of(source_select_q);
	always_comb begin
		src_edge = src_rise[0];
		case (cur_src)
			rtc_pkg::src_low_power: src_edge = src_rise[0];
			rtc_pkg::src_ext: src_edge = src_rise[1];
			rtc_pkg::src_int: src_edge = src_rise[2];
			default:          src_edge = src_rise[0];
		endcase
	end

	// =============================================
	// Prescaler
	rtc_prescaler #(
		.DIV_W (18)
	) u_prescaler (
		.clk             (clk),
		.reset           (reset),
		.clear           (clear),
		.prescale_select (prescale_select_q),
		.bank            (source_select_q[0]),
		.src_edge        (src_edge),
		.tick            (tick)
	);

	// =============================================
	// Write decode and clear conditions
	assign tsc_wr   = wr && (addr == `TSC_OFFSET);
	assign limit_wr = wr && (addr == `LIMIT_OFFSET);
	assign new_sel  = wdata[`SEL_HI:`SEL_LO];
	assign new_ps   = wdata[`PS_HI:`PS_LO];

	// Clear on limit write or on a changed source or prescale select
	assign clear = limit_wr
		|| (tsc_wr && (new_sel != source_select_q))
		|| (tsc_wr && (new_ps != prescale_select_q));

	// Counter passes from the limit to zero
	assign wrap = tick && !clear && (count_value_q == compare_limit_q);

	// =============================================
	// Control registers
	always_comb begin
		source_select_d       = source_select_q;
		prescale_select_d     = prescale_select_q;
		periodic_irq_enable_d = periodic_irq_enable_q;
		compare_limit_d       = compare_limit_q;
		if (reset) begin
			source_select_d       = `SEL_RESET;
			prescale_select_d     = `PS_OFF;
			periodic_irq_enable_d = 1'b0;
			compare_limit_d       = `BYTE_ZERO;
		end else if (tsc_wr) begin
			source_select_d       = new_sel;
			prescale_select_d     = new_ps;
			periodic_irq_enable_d = wdata[`IE_BIT];
		end else if (limit_wr) begin
			compare_limit_d = wdata;
		end
	end

	always_ff @(posedge clk) begin
		source_select_q       <= source_select_d;
		prescale_select_q     <= prescale_select_d;
		periodic_irq_enable_q <= periodic_irq_enable_d;
		compare_limit_q       <= compare_limit_d;
	end

	// =============================================
	// Counter and flag
	always_comb begin
		count_value_d   = count_value_q;
		periodic_flag_d = periodic_flag_q;
		if (reset) begin
			count_value_d   = `BYTE_ZERO;
			periodic_flag_d = 1'b0;
		end else begin
			if (clear) begin
				count_value_d = `BYTE_ZERO;
			end else if (wrap) begin
				count_value_d = `BYTE_ZERO;
			end else if (tick) begin
				count_value_d = count_value_q + `BYTE_ONE;
			end
			// Set wins over a write-one clear; writing zero keeps the flag
			if (wrap) begin
				periodic_flag_d = 1'b1;
			end else if (tsc_wr && wdata[`FLAG_BIT]) begin
				periodic_flag_d = 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		count_value_q   <= count_value_d;
		periodic_flag_q <= periodic_flag_d;
	end

	// =============================================
	// Read data and interrupt output
	always_comb begin
		rdata_d = `BYTE_ZERO;
		irq_d   = 1'b0;
		if (!reset) begin
			irq_d = periodic_flag_q && periodic_irq_enable_q;
			if (rd) begin
				if (addr == `TSC_OFFSET) begin
					rdata_d = {periodic_flag_q, source_select_q, periodic_irq_enable_q, prescale_select_q};
				end else if (addr == `COUNT_OFFSET) begin
					rdata_d = count_value_q;
				end else if (addr == `LIMIT_OFFSET) begin
					rdata_d = compare_limit_q;
				end else begin
					rdata_d = `BYTE_ZERO;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		rdata_q <= rdata_d;
		irq_q   <= irq_d;
	end

	assign rdata = rdata_q;
	assign irq   = irq_q;

	// =============================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence wrap_s;
		tick && !clear && (count_value_q == compare_limit_q);
	endsequence

	sequence step_s;
		tick && !clear && (count_value_q != compare_limit_q);
	endsequence

	sequence w1c_s;
		tsc_wr && wdata[`FLAG_BIT] && !wrap;
	endsequence

	reset_values_a: assert property ($past(reset) |-> count_value_q == 8'h00 && compare_limit_q == 8'h00
		&& prescale_select_q == 4'h0 && !periodic_flag_q)
		else $error("state not cleared by reset");

	reset_source_a: assert property ($past(reset) |-> source_select_q == 2'h0)
		else $error("reset source not low power oscillator");

	prescaler_off_a: assert property (prescale_select_q == 4'h0 |-> !tick)
		else $error("tick while prescaler off");

	source_mux_a: assert property (src_edge == (source_select_q == 2'h0 ? src_rise[0] :
		source_select_q == 2'h1 ? src_rise[1] : src_rise[2]))
		else $error("wrong clock source selected");

	source_clear_a: assert property (tsc_wr && new_sel != source_select_q |=> count_value_q == 8'h00)
		else $error("source change did not clear count");

	prescale_clear_a: assert property (tsc_wr && new_ps != prescale_select_q |=> count_value_q == 8'h00)
		else $error("prescale change did not clear count");

	limit_write_a: assert property (limit_wr |=> count_value_q == 8'h00 && compare_limit_q == $past(wdata))
		else $error("limit write wrong");

	count_step_a: assert property (step_s |=> count_value_q == $past(count_value_q) + 8'h01)
		else $error("count did not step");

	wrap_flag_a: assert property (wrap_s |=> count_value_q == 8'h00 && periodic_flag_q)
		else $error("wrap did not clear count and set flag");

	flag_cause_a: assert property ($rose(periodic_flag_q) |-> $past(wrap))
		else $error("flag set without wrap");

	irq_follow_a: assert property (periodic_flag_q && periodic_irq_enable_q |=> irq_q)
		else $error("interrupt not raised");

	irq_mask_a: assert property (!(periodic_flag_q && periodic_irq_enable_q) |=> !irq_q)
		else $error("interrupt raised while masked or clear");

	flag_clear_a: assert property (w1c_s |=> !periodic_flag_q ##1 !irq_q)
		else $error("flag not cleared by write one");

	flag_keep_a: assert property (tsc_wr && !wdata[`FLAG_BIT] && periodic_flag_q |=> periodic_flag_q)
		else $error("writing zero cleared flag");

	count_ro_a: assert property (wr && addr == `COUNT_OFFSET && !tick |=> $stable(count_value_q))
		else $error("count register took a write");

	count_read_a: assert property (rd && addr == `COUNT_OFFSET |=> rdata_q == $past(count_value_q))
		else $error("count read wrong");

	// Read port: data only in the cycle after a strobe, zero otherwise
	rdata_idle_a: assert property (!rd |=> rdata_q == 8'h00)
		else $error("read data outside read cycle");

	unmapped_read_a: assert property (rd && addr == 2'h3 |=> rdata_q == 8'h00)
		else $error("unmapped read not zero");

	limit_read_a: assert property (rd && addr == `LIMIT_OFFSET |=> rdata_q == $past(compare_limit_q))
		else $error("limit read wrong");

	status_read_a: assert property (rd && addr == `TSC_OFFSET |=> rdata_q == {$past(periodic_flag_q),
		$past(source_select_q), $past(periodic_irq_enable_q), $past(prescale_select_q)})
		else $error("status read wrong");

	// Counter and flag invariants
	count_bound_a: assert property (count_value_q <= compare_limit_q)
		else $error("count above limit");

	count_hold_a: assert property (!tick && !clear |=> $stable(count_value_q))
		else $error("count moved without tick");

	clear_no_flag_a: assert property (clear |=> !$rose(periodic_flag_q))
		else $error("flag set by clearing write");

	flag_hold_a: assert property (periodic_flag_q && !(tsc_wr && wdata[`FLAG_BIT]) |=> periodic_flag_q)
		else $error("flag lost without write one");

	flag_quiet_a: assert property (!periodic_flag_q && !wrap |=> !periodic_flag_q)
		else $error("flag set before wrap");

endmodule // periodic_realtime_counter

// *** sim/test_periodic_realtime_counter.sv ***
// Self-checking bench for the periodic real-time counter
`timescale 1ns/1ps
`include "rtc_consts.svh"

module test_periodic_realtime_counter;
	logic           clk;
	logic           reset;
	logic [1:0]     addr;
	logic [7:0]     wdata;
	logic           wr;
	logic           rd;
	rtc_pkg::byte_t rdata;
	logic           irq;
	logic [2:0]     src;
	int             fail_count;
	int             comparisons;
	int             codes [9]  = '{1, 2, 3, 4, 9, 10, 11, 12, 13};
	int             ratios [9] = '{8, 32, 64, 128, 2, 4, 10, 16, 100};

	// =============================================
	// Clock and device
	initial clk = 1'b0;
	always #5 clk = ~clk;

	periodic_realtime_counter i_dut (
		.clk                (clk),
		.reset              (reset),
		.addr               (addr),
		.wdata              (wdata),
		.wr                 (wr),
		.rd                 (rd),
		.rdata              (rdata),
		.irq                (irq),
		.low_power_osc      (src[0]),
		.external_ref_clock (src[1]),
		.internal_ref_clock (src[2])
	);

	// =============================================
	// Shared tasks
	task automatic end_of_test();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input rtc_pkg::byte_t got, input rtc_pkg::byte_t exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic rtc_pkg::byte_t ctl(input logic [1:0] sel, input logic ie, input logic [3:0] ps);
		return {1'b0, sel, ie, ps};
	endfunction

	task automatic wr_reg(input logic [1:0] a, input rtc_pkg::byte_t d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd_chk(input logic [1:0] a, input rtc_pkg::byte_t exp);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask

	// Waits a few cycles for the interrupt level to settle
	task automatic irq_wait(input logic exp);
		for (int i = 0; i < 4 && irq !== exp; i++) begin
			@(posedge clk);
			#1;
		end
		chk({7'h0, irq}, {7'h0, exp});
	endtask

	// Source rises for 4 cycles, falls for 4
	task automatic pulse(input int idx, input int n);
		repeat (n) begin
			@(posedge clk);
			src[idx] <= 1'b1;
			repeat (4) @(posedge clk);
			src[idx] <= 1'b0;
			repeat (3) @(posedge clk);
		end
	endtask

	task automatic do_reset();
		@(posedge clk);
		reset <= 1'b1;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
	endtask

	// =============================================
	// Scenarios
	task automatic t_reset();
		rd_chk(`TSC_OFFSET, 8'h00);
		rd_chk(`COUNT_OFFSET, 8'h00);
		rd_chk(`LIMIT_OFFSET, 8'h00);
		rd_chk(2'h3, 8'h00);
		irq_wait(1'b0);
	endtask

	task automatic t_off();
		wr_reg(`LIMIT_OFFSET, 8'h05);
		pulse(0, 4);
		rd_chk(`COUNT_OFFSET, 8'h00);
	endtask

	task automatic t_wrap();
		wr_reg(`TSC_OFFSET, ctl(2'b00, 1'b0, 4'h8));
		wr_reg(`LIMIT_OFFSET, 8'h03);
		pulse(0, 3);
		rd_chk(`COUNT_OFFSET, 8'h03);
		rd_chk(`TSC_OFFSET, 8'h08);
		pulse(0, 1);
		rd_chk(`COUNT_OFFSET, 8'h00);
		rd_chk(`TSC_OFFSET, 8'h88);
		irq_wait(1'b0);
		wr_reg(`TSC_OFFSET, ctl(2'b00, 1'b1, 4'h8));
		rd_chk(`TSC_OFFSET, 8'h98);
		irq_wait(1'b1);
		wr_reg(`TSC_OFFSET, 8'h98);
		rd_chk(`TSC_OFFSET, 8'h18);
		irq_wait(1'b0);
	endtask

	task automatic t_regs();
		pulse(0, 2);
		wr_reg(`COUNT_OFFSET, 8'h55);
		rd_chk(`COUNT_OFFSET, 8'h02);
		wr_reg(`LIMIT_OFFSET, 8'hFF);
		rd_chk(`LIMIT_OFFSET, 8'hFF);
		rd_chk(`COUNT_OFFSET, 8'h00);
	endtask

	task automatic t_limit0();
		wr_reg(`LIMIT_OFFSET, 8'h00);
		pulse(0, 1);
		rd_chk(`TSC_OFFSET, 8'h98);
		wr_reg(`TSC_OFFSET, 8'h98);
		rd_chk(`TSC_OFFSET, 8'h18);
		pulse(0, 1);
		rd_chk(`TSC_OFFSET, 8'h98);
		wr_reg(`TSC_OFFSET, 8'h88);
		irq_wait(1'b0);
	endtask

	// Half a period, then a limit write, must restart the prescaler
	task automatic t_ratio();
		for (int k = 0; k < 9; k++) begin
			wr_reg(`TSC_OFFSET, ctl(2'b00, 1'b0, codes[k][3:0]));
			rd_chk(`COUNT_OFFSET, 8'h00);
			pulse(0, ratios[k] / 2);
			wr_reg(`LIMIT_OFFSET, 8'hFF);
			pulse(0, ratios[k] - 1);
			rd_chk(`COUNT_OFFSET, 8'h00);
			pulse(0, 1);
			rd_chk(`COUNT_OFFSET, 8'h01);
		end
	endtask

	task automatic t_source();
		wr_reg(`TSC_OFFSET, ctl(2'b01, 1'b0, 4'h8));
		pulse(0, 2);
		pulse(2, 2);
		pulse(1, 999);
		rd_chk(`COUNT_OFFSET, 8'h00);
		pulse(1, 1);
		rd_chk(`COUNT_OFFSET, 8'h01);
		wr_reg(`TSC_OFFSET, ctl(2'b10, 1'b0, 4'h8));
		rd_chk(`COUNT_OFFSET, 8'h00);
		pulse(1, 2);
		pulse(0, 2);
		pulse(2, 3);
		rd_chk(`COUNT_OFFSET, 8'h03);
		wr_reg(`TSC_OFFSET, ctl(2'b11, 1'b0, 4'h8));
		rd_chk(`COUNT_OFFSET, 8'h00);
		pulse(2, 1000);
		rd_chk(`COUNT_OFFSET, 8'h01);
		wr_reg(`TSC_OFFSET, ctl(2'b11, 1'b0, 4'h8));
		rd_chk(`COUNT_OFFSET, 8'h01);
	endtask

	// Flag and interrupt set, then a mid-run reset must clear them
	task automatic t_flag_reset();
		wr_reg(`TSC_OFFSET, ctl(2'b00, 1'b1, 4'h8));
		wr_reg(`LIMIT_OFFSET, 8'h00);
		pulse(0, 1);
		irq_wait(1'b1);
		rd_chk(`TSC_OFFSET, 8'h98);
		do_reset();
		t_reset();
	endtask

	// =============================================
	// Main sequence and watchdog
	initial begin
		fail_count  = 0;
		comparisons = 0;
		reset       = 1'b1;
		addr        = 2'h0;
		wdata       = 8'h00;
		wr          = 1'b0;
		rd          = 1'b0;
		src         = 3'h0;
		do_reset();
		t_reset();
		t_off();
		t_wrap();
		t_regs();
		t_limit0();
		t_ratio();
		t_source();
		t_flag_reset();
		end_of_test();
	end

	initial begin
		repeat (100000) @(posedge clk);
		fail_count++;
		end_of_test();
	end
endmodule // test_periodic_realtime_counter
